/* File: bench/arc_ctrl_asserts.sv */
// Purpose: Port-level checks of result latching and the end flag
// Assumes: clk_en held high; single clock domain
// Notes: Bound to every arc_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module arc_ctrl_asserts #(
    parameter int RES_W = 10,
    parameter int SAMPLE_CYC = 4,
    parameter int SETTLE_CYC = 25
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic mode_wr,
    input wire logic chan_wr,
    input wire logic pcfg_lo_wr,
    input wire logic pcfg_hi_wr,
    input wire logic result_rd,
    input wire logic flag_clr,
    input wire logic sample_on,
    input wire logic [7:0] converter_mode_reg,
    input wire logic [15:0] result_word,
    input wire logic [7:0] result_low_byte,
    input wire logic [7:0] result_high_byte,
    input wire logic conversion_end_irq,
    input wire logic conversion_end_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic cfg_wr;
    assign cfg_wr = mode_wr | chan_wr | pcfg_lo_wr | pcfg_hi_wr;
    irq_pulse_a: assert property (conversion_end_irq |=> !conversion_end_irq)
        else $error("end pulse longer than one cycle");
    flag_set_a: assert property (conversion_end_irq |-> conversion_end_flag)
        else $error("end pulse without flag");
    flag_rise_a: assert property ($rose(conversion_end_flag) |-> conversion_end_irq)
        else $error("flag set without completion");
    flag_fall_a: assert property ($fell(conversion_end_flag) |-> $past(flag_clr))
        else $error("flag cleared without software clear");
    flag_clear_a: assert property (flag_clr |=> conversion_end_flag == conversion_end_irq)
        else $error("flag clear not honoured");
    conflict_drop_a: assert property (conversion_end_irq |-> !$past(cfg_wr))
        else $error("completion posted during config write");
    read_old_a: assert property (conversion_end_irq && $past(result_rd) |-> $stable(result_word))
        else $error("result replaced during read");
    result_change_a: assert property (!$stable(result_word) |->
        conversion_end_irq || ($past(conversion_end_irq) && $past(result_rd, 2)))
        else $error("result changed without completion");
    stop_hold_a: assert property (!converter_mode_reg[7] |-> !sample_on && !conversion_end_irq)
        else $error("activity with start bit clear");
    restart_a: assert property (chan_wr && converter_mode_reg[7] && !mode_wr |=> sample_on)
        else $error("channel rewrite did not restart");
    view_map_a: assert property ({result_high_byte, result_low_byte} == result_word
        && result_word[5:0] == 6'h00)
        else $error("result views disagree");
    cover property (conversion_end_irq && $past(result_rd));
    cover property (chan_wr && converter_mode_reg[7]);
    cover property ($fell(converter_mode_reg[7]));
endmodule
bind arc_ctrl arc_ctrl_asserts #(.RES_W(RES_W), .SAMPLE_CYC(SAMPLE_CYC), .SETTLE_CYC(SETTLE_CYC))
    u_chk (.clk(clk), .rstn(rstn), .mode_wr(mode_wr), .chan_wr(chan_wr),
    .pcfg_lo_wr(pcfg_lo_wr), .pcfg_hi_wr(pcfg_hi_wr), .result_rd(result_rd),
    .flag_clr(flag_clr), .sample_on(sample_on), .converter_mode_reg(converter_mode_reg),
    .result_word(result_word), .result_low_byte(result_low_byte),
    .result_high_byte(result_high_byte), .conversion_end_irq(conversion_end_irq),
    .conversion_end_flag(conversion_end_flag));
`default_nettype wire

/* File: bench/arc_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the converter result and flag control
// Assumes: Ideal comparator fed from a bench voltage code
// Notes: Short settle count keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module arc_ctrl_tb_top;
    localparam int SC = 4;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] stb = 6'h00;
    logic [7:0] wdata = 8'h00;
    logic [9:0] vin = 10'h2A5;
    logic cmp_ge;
    logic [9:0] dac_code;
    logic sample_on, conversion_end_irq, conversion_end_flag, first_result_suspect;
    logic [7:0] converter_mode_reg, channel_select_reg, port_analog_config_lo;
    logic [7:0] port_analog_config_hi, result_low_byte, result_high_byte;
    logic [15:0] result_word;
    int mismatches = 0;
    int tests_run = 0;
    int n;
    // Ideal comparator so every result code is known in advance
    assign cmp_ge = (vin >= dac_code);
    always #20 clk = ~clk;
    arc_ctrl #(.SAMPLE_CYC(SC), .SETTLE_CYC(2)) dut (
        .clk(clk), .rstn(rstn), .clk_en(1'b1), .mode_wr(stb[0]), .mode_wdata(wdata),
        .chan_wr(stb[1]), .chan_wdata(wdata), .pcfg_lo_wr(stb[2]), .pcfg_lo_wdata(wdata),
        .pcfg_hi_wr(stb[3]), .pcfg_hi_wdata(wdata), .result_rd(stb[4]), .flag_clr(stb[5]),
        .cmp_ge(cmp_ge), .dac_code(dac_code), .sample_on(sample_on),
        .converter_mode_reg(converter_mode_reg), .channel_select_reg(channel_select_reg),
        .port_analog_config_lo(port_analog_config_lo),
        .port_analog_config_hi(port_analog_config_hi), .result_word(result_word),
        .result_low_byte(result_low_byte), .result_high_byte(result_high_byte),
        .conversion_end_irq(conversion_end_irq), .conversion_end_flag(conversion_end_flag),
        .first_result_suspect(first_result_suspect));
    task automatic finish_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    // One-cycle strobe: 0 mode, 1 channel, 2 port lo, 3 port hi, 4 read, 5 flag clear
    task automatic pulse(input int k, input logic [7:0] d);
        stb[k] = 1'b1;
        wdata = d;
        cyc(1);
        stb[k] = 1'b0;
    endtask
    // Counts edges until the end pulse shows; bounded so a hang ends the run
    task automatic wait_irq(output int c);
        c = 0;
        do begin
            cyc(1);
            c++;
            if (c > 200) begin
                mismatches++;
                finish_test();
            end
        end while (conversion_end_irq !== 1'b1);
    endtask
    initial begin
        cyc(10);
        rstn = 1'b1;
        cyc(3);
        check(result_word, 16'h0000);
        check({result_high_byte, result_low_byte}, 16'h0000);
        pulse(0, 8'h81);
        wait_irq(n);
        // Sampling cycles plus one edge per trial bit
        check(n[15:0], SC + 10);
        check({result_high_byte, result_low_byte}, {vin, 6'h00});
        check(first_result_suspect, 1'b1);
        vin = 10'h15A;
        wait_irq(n);
        check(n[15:0], SC + 10);
        check(result_word, {10'h15A, 6'h00});
        // read before writes
        // Read lands on the next completion edge
        vin = 10'h0F0;
        cyc(SC + 9);
        pulse(4, 8'h00);
        check(conversion_end_irq, 1'b1);
        check(result_word, {10'h15A, 6'h00});
        cyc(1);
        check(result_word, {10'h0F0, 6'h00});
        // Channel rewrite in mid-conversion keeps the old flag
        vin = 10'h3FF;
        cyc(5);
        pulse(1, 8'h03);
        check(conversion_end_flag, 1'b1);
        check(channel_select_reg, 8'h03);
        wait_irq(n);
        check(n[15:0], SC + 10);
        check(result_word, 16'hFFC0);
        pulse(5, 8'h00);
        check(conversion_end_flag, 1'b0);
        // Port write on the completion edge wins
        vin = 10'h001;
        cyc(SC + 8);
        pulse(3, 8'h05);
        check(conversion_end_irq, 1'b0);
        check(conversion_end_flag, 1'b0);
        check(port_analog_config_hi, 8'h05);
        cyc(1);
        check(result_word, 16'hFFC0);
        cyc(5);
        pulse(0, 8'h01);
        cyc(40);
        check(sample_on, 1'b0);
        check(conversion_end_flag, 1'b0);
        check(result_word, 16'hFFC0);
        // Enable long settled: first result trusted
        pulse(0, 8'h81);
        wait_irq(n);
        check(first_result_suspect, 1'b0);
        check(result_word, {10'h001, 6'h00});
        cyc(1);
        pulse(0, 8'h00);
        cyc(1);
        pulse(5, 8'h00);
        check(conversion_end_flag, 1'b0);
        cyc(1);
        pulse(0, 8'h80);
        wait_irq(n);
        check(first_result_suspect, 1'b1);
        cyc(1);
        pulse(0, 8'h00);
        cyc(1);
        pulse(5, 8'h00);
        cyc(1);
        // Enable then start one cycle later, inside the settle time
        stb[0] = 1'b1;
        wdata = 8'h01;
        cyc(1);
        wdata = 8'h81;
        cyc(1);
        stb[0] = 1'b0;
        wait_irq(n);
        check(n[15:0], SC + 10);
        check(first_result_suspect, 1'b1);
        check(result_word, {10'h001, 6'h00});
        finish_test();
    end
endmodule
`default_nettype wire

/* File: include/arc_params.svh */
// Purpose: Constants for the converter result and flag control block
// Assumes: 25 MHz clock
// Notes: Bit positions of the mode register and timing counts
`ifndef ARC_PARAMS_SVH
`define ARC_PARAMS_SVH
`define ARC_RES_W 10
`define ARC_MODE_START_BIT 7
`define ARC_MODE_ENABLE_BIT 0
`define ARC_CLK_MHZ 25
`define ARC_SETTLE_US 1
`define ARC_SETTLE_CYC (`ARC_SETTLE_US * `ARC_CLK_MHZ)
`define ARC_SAMPLE_CYC 4
`define ARC_RESULT_RST 16'h0000
`define ARC_BYTE_RST 8'h00
`define ARC_MODE_RST 8'h00
`define ARC_CHAN_RST 8'h00
`define ARC_PCFG_LO_RST 8'h00
`define ARC_PCFG_HI_RST 8'h07
`endif

/* File: include/arc_pkg.sv */
// Purpose: Types for the converter result and flag control block
// Assumes: Nothing
// Notes: Sequencer states only
package arc_pkg;
    typedef enum logic [1:0] {
        ARC_IDLE = 2'b00,
        ARC_SAMPLE = 2'b01,
        ARC_CONVERT = 2'b10
    } arc_state_t;
endpackage

/* File: verilog/arc_ctrl.sv */
// Purpose: Result latching, end flag and register-write conflicts of the converter
// Assumes: Software accesses arrive as one-cycle strobes synchronous to clk
// Notes: Analog front end is outside; comparator answer is an input
`timescale 1ns/1ps
`default_nettype none
`include "arc_params.svh"
// Notes on behaviour
// - A result read in the completion cycle returns old data; new result stored next.
// - Mode, channel or port write at completion drops the result and interrupt.
// - Channel-select rewrite never clears the end flag.
// - Flag seen just after a channel rewrite may belong to the old channel.
// - Start within 1 us of enable, or with enable clear, gives a suspect result.
// - Register writes may spoil results; software reads results first.
// - Result code is 10 bits, one step per 1/1024 full scale.
// - Conversion time includes the sampling interval.
// - Channel rewrite during conversion aborts and restarts on new channel.
// - Clearing the start bit stops conversion at once; last result kept.
// - With start bit set, next conversion begins right after each completes.
// - Reset clears result word and both byte views to zero.
module arc_ctrl #(
    parameter int RES_W = `ARC_RES_W,
    parameter int SAMPLE_CYC = `ARC_SAMPLE_CYC,
    parameter int SETTLE_CYC = `ARC_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic mode_wr,
    input wire logic [7:0] mode_wdata,
    input wire logic chan_wr,
    input wire logic [7:0] chan_wdata,
    input wire logic pcfg_lo_wr,
    input wire logic [7:0] pcfg_lo_wdata,
    input wire logic pcfg_hi_wr,
    input wire logic [7:0] pcfg_hi_wdata,
    input wire logic result_rd,
    input wire logic flag_clr,
    input wire logic cmp_ge,
    output logic [RES_W-1:0] dac_code,
    output logic sample_on,
    output logic [7:0] converter_mode_reg,
    output logic [7:0] channel_select_reg,
    output logic [7:0] port_analog_config_lo,
    output logic [7:0] port_analog_config_hi,
    output logic [15:0] result_word,
    output logic [7:0] result_low_byte,
    output logic [7:0] result_high_byte,
    output logic conversion_end_irq,
    output logic conversion_end_flag,
    output logic first_result_suspect
);
    logic rst_s1_q, rst_n_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    localparam int SMP_W = $clog2(SAMPLE_CYC + 1);
    localparam int SET_W = $clog2(SETTLE_CYC + 1);

    arc_pkg::arc_state_t st_q, st_d;
    logic [SMP_W-1:0] smp_q, smp_d;
    logic [SET_W-1:0] settle_q, settle_d;
    logic [7:0] mode_q, mode_d, chan_q, chan_d, plo_q, plo_d, phi_q, phi_d;
    logic [15:0] res_q, res_d;
    logic [RES_W-1:0] pend_q, pend_d;
    logic pend_v_q, pend_v_d;
    logic flag_q, flag_d, irq_q, irq_d;
    logic susp_q, susp_d, first_q, first_d;
    logic sar_go, sar_abort, sar_done;
    logic [RES_W-1:0] sar_res;
    logic cfg_wr, start_bit, en_bit, start_req;

    assign start_bit = mode_q[`ARC_MODE_START_BIT];
    assign en_bit = mode_q[`ARC_MODE_ENABLE_BIT];
    assign cfg_wr = mode_wr | chan_wr | pcfg_lo_wr | pcfg_hi_wr;
    assign start_req = mode_wr && mode_wdata[`ARC_MODE_START_BIT] && !start_bit;

    arc_sar #(
        .RES_W(RES_W)
    ) u_sar (
        .clk(clk),
        .rst_n(rst_n_q),
        .ce(clk_en),
        .go(sar_go),
        .abort(sar_abort),
        .cmp_ge(cmp_ge),
        .trial(dac_code),
        .done(sar_done),
        .result(sar_res)
    );

    assign sample_on = (st_q == arc_pkg::ARC_SAMPLE);
    assign converter_mode_reg = mode_q;
    assign channel_select_reg = chan_q;
    assign port_analog_config_lo = plo_q;
    assign port_analog_config_hi = phi_q;
    assign result_word = res_q;
    // Byte views decode from the one stored word so they never disagree
    assign result_low_byte = res_q[7:0];
    assign result_high_byte = res_q[15:8];
    assign conversion_end_flag = flag_q;
    assign conversion_end_irq = irq_q;
    assign first_result_suspect = susp_q;

    always_comb begin
        st_d = st_q;
        smp_d = smp_q;
        settle_d = settle_q;
        mode_d = mode_wr ? mode_wdata : mode_q;
        chan_d = chan_wr ? chan_wdata : chan_q;
        plo_d = pcfg_lo_wr ? pcfg_lo_wdata : plo_q;
        phi_d = pcfg_hi_wr ? pcfg_hi_wdata : phi_q;
        res_d = res_q;
        pend_d = pend_q;
        pend_v_d = 1'b0;
        flag_d = flag_q;
        irq_d = 1'b0;
        susp_d = susp_q;
        first_d = first_q;
        sar_go = 1'b0;
        sar_abort = 1'b0;
        if (mode_wr && mode_wdata[`ARC_MODE_ENABLE_BIT] && !en_bit) begin
            settle_d = SET_W'(SETTLE_CYC);
        end else if (settle_q != '0) begin
            settle_d = settle_q - SET_W'(1);
        end
        if (!mode_d[`ARC_MODE_ENABLE_BIT]) begin
            settle_d = '0;
        end
        if (start_req) begin
            first_d = !en_bit || (settle_q != '0) || !mode_wdata[`ARC_MODE_ENABLE_BIT];
        end
        if (pend_v_q) begin
            res_d = {pend_q, {(16-RES_W){1'b0}}};
        end
        if (flag_clr) begin
            flag_d = 1'b0;
        end
        // stop at once on start clear
        if (mode_wr && !mode_wdata[`ARC_MODE_START_BIT]) begin
            st_d = arc_pkg::ARC_IDLE;
            sar_abort = 1'b1;
        end else if (start_req || (chan_wr && start_bit)) begin
            st_d = arc_pkg::ARC_SAMPLE;
            smp_d = SMP_W'(SAMPLE_CYC);
            sar_abort = 1'b1;
        end else begin
            case (st_q)
                arc_pkg::ARC_IDLE: begin
                    st_d = arc_pkg::ARC_IDLE;
                end
                arc_pkg::ARC_SAMPLE: begin
                    if (smp_q <= SMP_W'(1)) begin
                        st_d = arc_pkg::ARC_CONVERT;
                        sar_go = 1'b1;
                    end else begin
                        smp_d = smp_q - SMP_W'(1);
                    end
                end
                arc_pkg::ARC_CONVERT: begin
                    if (sar_done) begin
                        st_d = arc_pkg::ARC_SAMPLE;
                        smp_d = SMP_W'(SAMPLE_CYC);
                        if (!cfg_wr) begin
                            flag_d = 1'b1;
                            irq_d = 1'b1;
                            susp_d = first_q;
                            first_d = 1'b0;
                            if (result_rd) begin
                                pend_d = sar_res;
                                pend_v_d = 1'b1;
                            end else begin
                                res_d = {sar_res, {(16-RES_W){1'b0}}};
                            end
                        end
                    end
                end
                default: begin
                    st_d = arc_pkg::ARC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= arc_pkg::ARC_IDLE;
            smp_q <= '0;
            settle_q <= '0;
            mode_q <= `ARC_MODE_RST;
            chan_q <= `ARC_CHAN_RST;
            plo_q <= `ARC_PCFG_LO_RST;
            phi_q <= `ARC_PCFG_HI_RST;
            res_q <= `ARC_RESULT_RST;
            pend_q <= '0;
            pend_v_q <= 1'b0;
            flag_q <= 1'b0;
            irq_q <= 1'b0;
            susp_q <= 1'b0;
            first_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            smp_q <= smp_d;
            settle_q <= settle_d;
            mode_q <= mode_d;
            chan_q <= chan_d;
            plo_q <= plo_d;
            phi_q <= phi_d;
            res_q <= res_d;
            pend_q <= pend_d;
            pend_v_q <= pend_v_d;
            flag_q <= flag_d;
            irq_q <= irq_d;
            susp_q <= susp_d;
            first_q <= first_d;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/arc_sar.sv */
// Purpose: Successive-approximation bit sequencer
// Assumes: Comparator answer valid in the cycle of each trial
// Notes: Abort clears the trial at once
`timescale 1ns/1ps
`default_nettype none
module arc_sar #(
    parameter int RES_W = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic go,
    input wire logic abort,
    input wire logic cmp_ge,
    output logic [RES_W-1:0] trial,
    output logic done,
    output logic [RES_W-1:0] result
);
    logic [RES_W-1:0] sar_q, sar_d;
    logic [RES_W-1:0] bit_q, bit_d;
    logic busy_q, busy_d;

    assign trial = sar_q | bit_q;
    assign result = cmp_ge ? trial : sar_q;
    assign done = busy_q && bit_q[0];

    always_comb begin
        sar_d = sar_q;
        bit_d = bit_q;
        busy_d = busy_q;
        if (abort) begin
            busy_d = 1'b0;
            bit_d = '0;
            sar_d = '0;
        end else if (go) begin
            busy_d = 1'b1;
            sar_d = '0;
            bit_d = {1'b1, {(RES_W-1){1'b0}}};
        end else if (busy_q) begin
            // Keep bit when input is at or above the trial level
            if (cmp_ge) begin
                sar_d = trial;
            end
            bit_d = bit_q >> 1;
            if (bit_q[0]) begin
                busy_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sar_q <= '0;
            bit_q <= '0;
            busy_q <= 1'b0;
        end else if (ce) begin
            sar_q <= sar_d;
            bit_q <= bit_d;
            busy_q <= busy_d;
        end
    end
endmodule
`default_nettype wire
